// >>> design/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// clock rates and timing
`define WDT_CORE_HZ      10000000
`define WDT_LS_HZ        32000
`define WDT_LS_CYCLES    (`WDT_CORE_HZ / `WDT_LS_HZ)
`define WDT_TIMEOUT_BASE 256

// register offsets
`define WDT_OFF_CTRL     8'h00
`define WDT_OFF_KEY      8'h04
`define WDT_OFF_STAT     8'h08
`define WDT_OFF_MASK     8'h0c

// key codes
`define WDT_KEY_FEED     16'haaaa
`define WDT_KEY_UNLOCK   16'h5555
`define WDT_KEY_START    16'hcccc
`define WDT_KEY_STOP     16'hdddd
`define WDT_KEY_INT_ON   16'h55aa
`define WDT_KEY_INT_OFF  16'haa55
`define WDT_KEY_WAKE_ON  16'h5a5a

// reset values
`define WDT_PSR_RST      4'h8
`define WDT_RUN_RST      1'b1
`define WDT_INTSEL_RST   1'b0
`define WDT_WAKE_RST     1'b0
`define WDT_MASK_RST     2'h1

// event status bits
`define WDT_EVT_W        2
`define WDT_EVT_TIMEOUT  0
`define WDT_EVT_LOCKED   1

`endif

// >>> design/wdt_pkg.sv
package wdt_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [21:0] rsvd_hi;
    logic        wake_en;
    logic [1:0]  rsvd_mid;
    logic        pend;
    logic        int_sel;
    logic        run_en;
    logic [3:0]  psr;
  } ctrl_reg_t;

  typedef enum logic {
    CNT_STOP = 1'b0,
    CNT_RUN  = 1'b1
  } cnt_mode_t;

  typedef struct packed {
    cnt_mode_t   mode;
    logic [15:0] div;
    logic [23:0] cnt;
    logic        expire;
  } cnt_state_t;

  typedef struct packed {
    ctrl_reg_t   ctrl;
    logic        unlock;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] rdata;
    logic        rst_req;
    logic        wake_req;
  } wdt_state_t;

endpackage : wdt_pkg

// >>> design/wdt_timeout_counter.sv
`timescale 1ns/100ps
`include "wdt_params.svh"

module wdt_timeout_counter #(
  parameter int unsigned LS_CYCLES    = `WDT_LS_CYCLES,
  parameter int unsigned TIMEOUT_BASE = `WDT_TIMEOUT_BASE
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [3:0] psr,
  // event
  output logic            expire
);

  wdt_pkg::cnt_state_t s_q;
  wdt_pkg::cnt_state_t s_d;
  logic [23:0]         limit;

  localparam logic [15:0] LS_LAST = 16'(LS_CYCLES - 1);
  localparam logic [23:0] BASE    = 24'(TIMEOUT_BASE);

  // ticks of the low-speed clock per timeout: base times 2^psr, code 0 gives the base alone
  assign limit = (BASE << psr) - 24'h000001; // [R03] [R04]

  always_comb begin
    s_d        = s_q;
    s_d.expire = 1'b0;
    if (!run || restart) begin // [R15]
      s_d.mode = run ? wdt_pkg::CNT_RUN : wdt_pkg::CNT_STOP;
      s_d.div  = 16'h0000;
      s_d.cnt  = 24'h000000;
    end else begin
      s_d.mode = wdt_pkg::CNT_RUN;
      // the low-speed tick is derived here so the count never depends on bus activity
      if (s_q.div == LS_LAST) begin // [R01]
        s_d.div = 16'h0000;
        if (s_q.cnt >= limit) begin
          s_d.cnt    = 24'h000000;
          s_d.expire = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 24'h000001;
        end
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expire = s_q.expire;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_stop_clears:    assert property (!run |=> s_q.cnt == 24'h000000 && !expire) // [R09]
    else $error("counter not held while stopped");
  a_restart_zero:   assert property (run && restart |=> s_q.cnt == 24'h000000 && s_q.div == 16'h0000) // [R15]
    else $error("restart did not clear the count");
  a_expire_at_lim:  assert property (run && !restart && s_q.div == LS_LAST && s_q.cnt == limit |=> expire) // [R03]
    else $error("expiry missed at the limit");
  a_no_early_exp:   assert property (expire |-> $past(s_q.cnt) == $past(limit)) // [R04]
    else $error("expiry before the limit");

endmodule : wdt_timeout_counter

// >>> design/key_protected_watchdog.sv
`timescale 1ns/100ps
`include "wdt_params.svh"

// How it works
// [R01] counter advances on a 32 kHz tick derived from the core clock
// [R02] reset prescale gives about two seconds of timeout
// [R03] timeout equals 256 low-speed ticks times the division factor
// [R04] prescale field bits 3:0 resets to 8; code n divides by 2^n
// [R05] a prescale write needs the 0x5555 key first, else ignored
// [R06] on expiry reset the system, or interrupt when select bit set
// [R07] pending bit 6 sets on expiry; feed key clears it
// [R08] software must feed with 0xAAAA or expiry resets the system
// [R09] run bit 4 resets high; 0xCCCC starts, 0xDDDD stops
// [R10] interrupt select bit 5 resets low; 0x55AA sets, 0xAA55 clears
// [R11] wake enable bit 9 resets low; 0x5A5A sets it
// [R12] key register takes 16-bit codes and reads as zero
// [R13] control at offset 0x0, key register at offset 0x4
// [R14] an unknown key code changes nothing
// [R15] feeding or starting restarts the count from zero

module key_protected_watchdog #(
  parameter int unsigned LS_CYCLES    = `WDT_LS_CYCLES,
  parameter int unsigned TIMEOUT_BASE = `WDT_TIMEOUT_BASE
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // register port
  input  wire wdt_pkg::bus_req_t bus_req,
  output logic [31:0]           rd_data,
  // system side
  output logic                  sys_rst_req,
  output logic                  wake_req,
  output logic                  irq
);

  localparam wdt_pkg::ctrl_reg_t CTRL_RST = '{
    rsvd_hi:  22'h000000,
    wake_en:  `WDT_WAKE_RST,
    rsvd_mid: 2'h0,
    pend:     1'b0,
    int_sel:  `WDT_INTSEL_RST,
    run_en:   `WDT_RUN_RST,
    psr:      `WDT_PSR_RST
  };

  wdt_pkg::wdt_state_t s_q;
  wdt_pkg::wdt_state_t s_d;
  wdt_pkg::ctrl_reg_t  wr_ctrl;
  logic                restart;
  logic                expire;
  logic                key_wr;
  logic                ctrl_wr;
  logic                locked_hit;

  function automatic logic key_is(input logic [31:0] wdata, input logic [15:0] code);
    key_is = (wdata[15:0] == code); // [R12]
  endfunction : key_is

  function automatic logic at(input logic [7:0] addr, input logic [7:0] off);
    at = (addr == off); // [R13]
  endfunction : at

  wdt_timeout_counter #(
    .LS_CYCLES    (LS_CYCLES),
    .TIMEOUT_BASE (TIMEOUT_BASE)
  ) wdt_timeout_counter_inst (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (s_q.ctrl.run_en),
    .restart  (restart),
    .psr      (s_q.ctrl.psr),
    .expire   (expire)
  );

  assign key_wr  = bus_req.wr && at(bus_req.addr, `WDT_OFF_KEY);
  assign ctrl_wr = bus_req.wr && at(bus_req.addr, `WDT_OFF_CTRL);
  assign wr_ctrl = wdt_pkg::ctrl_reg_t'(bus_req.wdata);

  always_comb begin
    s_d          = s_q;
    s_d.rdata    = 32'h00000000;
    s_d.rst_req  = 1'b0;
    s_d.wake_req = 1'b0;
    restart      = 1'b0;
    locked_hit   = 1'b0;

    if (key_wr) begin
      if (key_is(bus_req.wdata, `WDT_KEY_FEED)) begin // [R08]
        restart       = 1'b1; // [R15]
        s_d.ctrl.pend = 1'b0; // [R07]
      end else if (key_is(bus_req.wdata, `WDT_KEY_UNLOCK)) begin
        s_d.unlock = 1'b1; // [R05]
      end else if (key_is(bus_req.wdata, `WDT_KEY_START)) begin
        s_d.ctrl.run_en = 1'b1; // [R09]
        restart         = 1'b1; // [R15]
      end else if (key_is(bus_req.wdata, `WDT_KEY_STOP)) begin
        s_d.ctrl.run_en = 1'b0; // [R09]
      end else if (key_is(bus_req.wdata, `WDT_KEY_INT_ON)) begin
        s_d.ctrl.int_sel = 1'b1; // [R10]
      end else if (key_is(bus_req.wdata, `WDT_KEY_INT_OFF)) begin
        s_d.ctrl.int_sel = 1'b0; // [R10]
      end else if (key_is(bus_req.wdata, `WDT_KEY_WAKE_ON)) begin
        s_d.ctrl.wake_en = 1'b1; // [R11]
      end
      // any other code falls through untouched [R14]
    end

    if (ctrl_wr) begin
      // run bit stays writable directly; pending, select and wake are read-only here
      s_d.ctrl.run_en = wr_ctrl.run_en; // [R09]
      if (s_q.unlock) begin
        s_d.ctrl.psr = wr_ctrl.psr; // [R05]
      end else begin
        locked_hit = 1'b1; // [R05]
      end
      // one unlock buys exactly one control write
      s_d.unlock = 1'b0;
    end

    if (bus_req.wr && at(bus_req.addr, `WDT_OFF_STAT)) begin
      s_d.status = s_q.status & ~bus_req.wdata[`WDT_EVT_W-1:0];
    end
    if (bus_req.wr && at(bus_req.addr, `WDT_OFF_MASK)) begin
      s_d.mask = bus_req.wdata[`WDT_EVT_W-1:0];
    end

    // sets come after clears so a same-cycle event is never lost
    if (locked_hit) begin
      s_d.status[`WDT_EVT_LOCKED] = 1'b1;
    end
    if (expire) begin
      s_d.ctrl.pend = 1'b1; // [R07]
      if (s_q.ctrl.int_sel) begin
        s_d.status[`WDT_EVT_TIMEOUT] = 1'b1; // [R06]
      end else begin
        s_d.rst_req = 1'b1; // [R06] [R08]
      end
      s_d.wake_req = s_q.ctrl.wake_en; // [R11]
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        `WDT_OFF_CTRL: s_d.rdata = s_q.ctrl; // [R13]
        `WDT_OFF_KEY:  s_d.rdata = 32'h00000000; // [R12]
        `WDT_OFF_STAT: s_d.rdata = {30'h00000000, s_q.status};
        `WDT_OFF_MASK: s_d.rdata = {30'h00000000, s_q.mask};
        default:       s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q.ctrl     <= CTRL_RST; // [R02] [R04] [R09] [R10] [R11]
      s_q.unlock   <= 1'b0;
      s_q.status   <= 2'h0;
      s_q.mask     <= `WDT_MASK_RST;
      s_q.rdata    <= 32'h00000000;
      s_q.rst_req  <= 1'b0;
      s_q.wake_req <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data     = s_q.rdata;
  assign sys_rst_req = s_q.rst_req;
  assign wake_req    = s_q.wake_req;
  assign irq         = |(s_q.status & s_q.mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_reset_values:  assert property ($fell(srst) |-> s_q.ctrl.psr == `WDT_PSR_RST && s_q.ctrl.run_en // [R04]
                                    && !s_q.ctrl.int_sel && !s_q.ctrl.wake_en)
    else $error("wrong control value after reset");
  a_reset_path:    assert property (expire && !s_q.ctrl.int_sel |=> sys_rst_req ##1 !sys_rst_req) // [R06]
    else $error("expiry in reset mode gave no one-cycle reset");
  a_int_path:      assert property (expire && s_q.ctrl.int_sel |=> !sys_rst_req && s_q.status[0]) // [R06]
    else $error("expiry in interrupt mode misrouted");
  a_pend_set:      assert property (expire |=> s_q.ctrl.pend) // [R07]
    else $error("pending not set on expiry");
  a_pend_feed:     assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_FEED) && !expire // [R07]
                                    |=> !s_q.ctrl.pend)
    else $error("feed key did not clear pending");
  a_psr_locked:    assert property (ctrl_wr && !s_q.unlock |=> $stable(s_q.ctrl.psr)) // [R05]
    else $error("prescale changed without unlock");
  a_psr_unlocked:  assert property (ctrl_wr && s_q.unlock |=> s_q.ctrl.psr == $past(wr_ctrl.psr) && !s_q.unlock) // [R05]
    else $error("unlocked prescale write not taken");
  a_run_keys:      assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_STOP) && !ctrl_wr // [R09]
                                    |=> !s_q.ctrl.run_en)
    else $error("stop key did not clear run");
  a_intsel_keys:   assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_INT_ON) |=> s_q.ctrl.int_sel) // [R10]
    else $error("interrupt select not set");
  a_wake_key:      assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_WAKE_ON) |=> s_q.ctrl.wake_en) // [R11]
    else $error("wake enable not set");
  a_key_reads_0:   assert property (bus_req.rd && at(bus_req.addr, `WDT_OFF_KEY) |=> rd_data == 32'h00000000) // [R12]
    else $error("key register read not zero");
  a_bad_key:       assert property (key_wr && !ctrl_wr && !expire && bus_req.wdata[15:0] != `WDT_KEY_FEED // [R14]
                                    && bus_req.wdata[15:0] != `WDT_KEY_UNLOCK && bus_req.wdata[15:0] != `WDT_KEY_START
                                    && bus_req.wdata[15:0] != `WDT_KEY_STOP && bus_req.wdata[15:0] != `WDT_KEY_INT_ON
                                    && bus_req.wdata[15:0] != `WDT_KEY_INT_OFF
                                    && bus_req.wdata[15:0] != `WDT_KEY_WAKE_ON
                                    |=> $stable(s_q.ctrl) && $stable(s_q.unlock))
    else $error("unknown key changed state");

  // unlock handling: one control write per unlock, other keys leave it armed
  a_locked_flag:   assert property (ctrl_wr && !s_q.unlock // [R05]
                                    |=> s_q.status[`WDT_EVT_LOCKED])
    else $error("locked prescale write not flagged");

  a_unlock_once:   assert property (ctrl_wr // [R05]
                                    |=> !s_q.unlock)
    else $error("unlock survived a control write");

  a_unlock_kept:   assert property (key_wr && s_q.unlock // [R05]
                                    |=> s_q.unlock)
    else $error("key write dropped the unlock");

  a_psr_keys:      assert property (key_wr // [R05]
                                    |=> $stable(s_q.ctrl.psr))
    else $error("key write changed prescale");

  // run and select bits
  a_run_direct:    assert property (ctrl_wr // [R09]
                                    |=> s_q.ctrl.run_en == $past(wr_ctrl.run_en))
    else $error("direct run write not taken");

  a_start_key:     assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_START) // [R09]
                                    |=> s_q.ctrl.run_en)
    else $error("start key did not set run");

  a_expire_runs:   assert property (expire // [R09]
                                    |-> $past(s_q.ctrl.run_en))
    else $error("expiry while stopped");

  a_intsel_off:    assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_INT_OFF) // [R10]
                                    |=> !s_q.ctrl.int_sel)
    else $error("interrupt select not cleared");

  a_intsel_hold:   assert property (!key_wr // [R10]
                                    |=> $stable(s_q.ctrl.int_sel))
    else $error("interrupt select moved without a key");

  // wake enable has no clearing key, so it stays until reset
  a_wake_hold:     assert property (s_q.ctrl.wake_en // [R11]
                                    |=> s_q.ctrl.wake_en)
    else $error("wake enable dropped");

  a_wake_path:     assert property (expire && s_q.ctrl.wake_en // [R11]
                                    |=> wake_req)
    else $error("expiry gave no wake request");

  a_wake_quiet:    assert property (!expire // [R11]
                                    |=> !wake_req)
    else $error("wake request without expiry");

  // system side pulses and flags
  a_rst_quiet:     assert property (!expire // [R06]
                                    |=> !sys_rst_req)
    else $error("reset request without expiry");

  a_pend_hold:     assert property (s_q.ctrl.pend && !key_wr // [R07]
                                    |=> s_q.ctrl.pend)
    else $error("pending dropped without feed");

  a_pend_only_exp: assert property (!s_q.ctrl.pend && !expire // [R07]
                                    |=> !s_q.ctrl.pend)
    else $error("pending set without expiry");

  a_stat_clear:    assert property (bus_req.wr && at(bus_req.addr, `WDT_OFF_STAT) // [R06]
                                    && bus_req.wdata[`WDT_EVT_TIMEOUT] && !expire
                                    |=> !s_q.status[`WDT_EVT_TIMEOUT])
    else $error("timeout event not cleared by write one");

  a_stat_hold:     assert property (s_q.status[`WDT_EVT_TIMEOUT] // [R06]
                                    && !(bus_req.wr && at(bus_req.addr, `WDT_OFF_STAT))
                                    |=> s_q.status[`WDT_EVT_TIMEOUT])
    else $error("timeout event dropped");

  a_feed_restart:  assert property (key_wr && key_is(bus_req.wdata, `WDT_KEY_FEED) // [R15]
                                    |=> !expire)
    else $error("expiry right after a feed");

  // register reads
  a_ctrl_read:     assert property (bus_req.rd && at(bus_req.addr, `WDT_OFF_CTRL) // [R13]
                                    |=> rd_data == $past(s_q.ctrl))
    else $error("control read wrong");

  a_rd_idle_zero:  assert property (!bus_req.rd // [R13]
                                    |=> rd_data == 32'h00000000)
    else $error("read data outside a read");

  c_wake_pulse:    cover property (wake_req);
  c_reset_expiry:  cover property (expire && !s_q.ctrl.int_sel);
  c_int_expiry:    cover property (expire && s_q.ctrl.int_sel ##1 irq);
  c_unlock_write:  cover property (key_wr && key_is(bus_req.wdata, `WDT_KEY_UNLOCK) ##1 ctrl_wr);
  c_locked_write:  cover property (ctrl_wr && !s_q.unlock);

endmodule : key_protected_watchdog

// >>> sim/key_protected_watchdog_tb.sv
`timescale 1ns/100ps
`include "wdt_params.svh"

module key_protected_watchdog_tb;
  logic              core_clk;
  logic              srst;
  wdt_pkg::bus_req_t bus_req;
  logic [31:0]       rd_data;
  logic              sys_rst_req;
  logic              wake_req;
  logic              irq;
  logic [31:0]       exp_q[$];
  logic              rd_pend;
  logic [15:0]       lfsr;
  logic [15:0]       k;
  int                fails;
  int                tests_run;
  int                rst_cnt;
  int                wake_cnt;
  int                per;
  int                c;

  // short tick and base keep the timeouts of prescale codes 0 to 3 within sixteen cycles
  key_protected_watchdog #(.LS_CYCLES(2), .TIMEOUT_BASE(1)) key_protected_watchdog_inst (
    .core_clk    (core_clk),
    .srst        (srst),
    .bus_req     (bus_req),
    .rd_data     (rd_data),
    .sys_rst_req (sys_rst_req),
    .wake_req    (wake_req),
    .irq         (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic is_key(input logic [15:0] v);
    return v inside {`WDT_KEY_FEED, `WDT_KEY_UNLOCK, `WDT_KEY_START, `WDT_KEY_STOP,
                     `WDT_KEY_INT_ON, `WDT_KEY_INT_OFF, `WDT_KEY_WAKE_ON};
  endfunction : is_key

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // called at a rising edge; for a read d is the value expected back
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= w;
    bus_req.rd    <= ~w;
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
  endtask : bus

  task automatic idle(input int n);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle

  // cycles between two system reset pulses, sampled away from the edge
  task automatic period(output int p);
    p = 0;
    for (int i = 0; i < 200 && sys_rst_req !== 1'b1; i++) @(negedge core_clk);
    do begin
      @(negedge core_clk);
      p++;
    end while (sys_rst_req !== 1'b1 && p < 200);
  endtask : period

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_pend) check(rd_data, exp_q.pop_front());
    rd_pend <= bus_req.rd;
    if (sys_rst_req === 1'b1) rst_cnt++;
    if (wake_req === 1'b1) wake_cnt++;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    stop_test();
  end

  initial begin
    bus_req = '0;
    srst = 1'b1;
    rd_pend = 1'b0;
    lfsr = 16'hb070;
    fails = 0;
    tests_run = 0;
    rst_cnt = 0;
    wake_cnt = 0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    bus(0, 8'h00, 32'h0000_0018);
    bus(0, 8'h04, 32'h0);
    bus(0, 8'h0c, 32'h1);
    bus(0, 8'h10, 32'h0);
    lfsr = lfsr_next(lfsr);
    bus(1, 8'h0c, {16'h0, lfsr});
    bus(0, 8'h0c, {30'h0, lfsr[1:0]});
    bus(1, 8'h04, {16'h0, `WDT_KEY_STOP});
    bus(1, 8'h00, 32'h3);         // no unlock first, so prescale must hold
    bus(0, 8'h00, 32'h0000_0008);
    bus(0, 8'h08, 32'h2);
    bus(1, 8'h08, 32'h2);
    bus(0, 8'h08, 32'h0);
    bus(1, 8'h04, {16'h0, `WDT_KEY_INT_ON});
    bus(0, 8'h00, 32'h0000_0028);
    bus(1, 8'h04, {16'h0, `WDT_KEY_INT_OFF});
    bus(0, 8'h00, 32'h0000_0008);
    bus(1, 8'h04, {16'h0, `WDT_KEY_WAKE_ON});
    bus(0, 8'h00, 32'h0000_0208);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      k = lfsr_next(lfsr);
      if (is_key(k)) k = 16'h1234;
      bus(1, 8'h04, {lfsr, k});
      bus(0, 8'h00, 32'h0000_0208);
    end
    idle(2);
    $display("registers and keys done");
    for (int p = 0; p < 4; p++) begin
      bus(1, 8'h04, {16'h0, `WDT_KEY_STOP});
      bus(1, 8'h04, {16'h0, `WDT_KEY_UNLOCK});
      bus(1, 8'h00, 32'h10 | p);
      idle(1);
      period(per);
      check(per, 2 << p);
      @(posedge core_clk);
    end
    bus(1, 8'h04, {16'h0, `WDT_KEY_STOP});
    bus(0, 8'h00, 32'h0000_0243);
    bus(1, 8'h04, {16'h0, `WDT_KEY_FEED});
    bus(0, 8'h00, 32'h0000_0203);
    idle(1);
    check({31'h0, wake_cnt != 0}, 32'h1);
    $display("expiry timing done");
    c = rst_cnt;
    bus(1, 8'h04, {16'h0, `WDT_KEY_UNLOCK});
    bus(1, 8'h00, 32'h12);
    // feeding every four cycles stays inside the eight-cycle timeout
    repeat (10) begin
      bus(1, 8'h04, {16'h0, `WDT_KEY_FEED});
      idle(3);
    end
    check(rst_cnt - c, 0);
    $display("feeding done");
    bus(1, 8'h04, {16'h0, `WDT_KEY_INT_ON});
    bus(1, 8'h08, 32'h3);
    idle(1);
    c = rst_cnt;
    for (int i = 0; i < 60 && irq !== 1'b1; i++) @(negedge core_clk);
    check(irq, 1'b1);
    check(rst_cnt - c, 0);
    @(posedge core_clk);
    bus(0, 8'h08, 32'h1);
    bus(1, 8'h0c, 32'h0);
    idle(1);
    @(negedge core_clk);
    check(irq, 1'b0);
    @(posedge core_clk);
    bus(1, 8'h04, {16'h0, `WDT_KEY_STOP});
    bus(1, 8'h0c, 32'h1);
    bus(1, 8'h08, 32'h1);
    idle(1);
    @(negedge core_clk);
    check(irq, 1'b0);
    @(posedge core_clk);
    idle(2);
    $display("interrupt done");
    stop_test();
  end
endmodule : key_protected_watchdog_tb
